// ### src/stir_pkg.sv
package stir_pkg;

    // ------------------------------------------------------------
    // bus addressing
    // ------------------------------------------------------------
    localparam logic [6:0] STIR_DEV_ADDR      = 7'h69;  // write byte d2, read byte d3
    localparam logic       STIR_DIR_WRITE     = 1'b0;
    localparam logic       STIR_DIR_READ      = 1'b1;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] STIR_IDX_TEST_CTRL = 8'h06;
    localparam logic [7:0] STIR_IDX_MAKER_REV = 8'h07;
    localparam logic [7:0] STIR_IDX_READ_LEN  = 8'h08;
    localparam logic [7:0] STIR_IDX_PART_ID   = 8'h09;

    // ------------------------------------------------------------
    // test control byte layout and reset
    // ------------------------------------------------------------
    localparam int         STIR_TEST_TYPE_POS  = 7;
    localparam int         STIR_TEST_ENTRY_POS = 6;
    localparam logic [7:0] STIR_TEST_CTRL_RST  = 8'h08;
    localparam logic [7:0] STIR_TEST_CTRL_WMSK = 8'hc0;

    // ------------------------------------------------------------
    // identity and length defaults (identity values arbitrary)
    // ------------------------------------------------------------
    localparam logic [3:0] STIR_REV_CODE      = 4'h3;
    localparam logic [3:0] STIR_MAKER_CODE    = 4'h5;
    localparam logic [7:0] STIR_PART_CODE     = 8'h77;
    localparam logic [7:0] STIR_READ_LEN_RST  = 8'h0a;

    // ------------------------------------------------------------
    // output modes and serial states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STIR_OUT_NORMAL,
        STIR_OUT_HIZ,
        STIR_OUT_REFDIV
    } stir_out_mode_type;

    typedef enum logic [3:0] {
        STIR_ST_IDLE,
        STIR_ST_ADDR,
        STIR_ST_ADDR_ACK,
        STIR_ST_INDEX,
        STIR_ST_INDEX_ACK,
        STIR_ST_COUNT,
        STIR_ST_COUNT_ACK,
        STIR_ST_WDATA,
        STIR_ST_WDATA_ACK,
        STIR_ST_RDATA,
        STIR_ST_RDATA_ACK,
        STIR_ST_SKIP
    } stir_state_type;

endpackage : stir_pkg

// ### src/stir_sync.sv
`timescale 1ns/1ps

module stir_sync
    import stir_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic d_i,
    output logic      q_o
);

    logic meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule : stir_sync

// ### src/stir_test_id_regs.sv
`timescale 1ns/1ps

// Summary of operation
// - in register-entered test mode the test-type bit picks divided reference (1) or hi-z (0), reset 0.
// - writing 1 to the test-entry bit enters test mode when the strap was low at power-up.
// - the test-entry bit resets to 0 and with it and the strap low the outputs run normally.
// - a high strap at power-up enters test mode whatever the test-entry bit holds.
// - in strap test mode outputs are hi-z only when test-output pin and test-type bit are both 0.
// - test mode, once entered, holds until power is cycled.
// - with the strap low at power-up, only the test-entry bit can enter test mode.
// - in register test mode the test-output pin is ignored and only the test-type bit counts.
// - the identity byte is read-only with revision code in bits 7..4 and maker code in bits 3..0.
// - the read-length byte is read-write, resets to ten and is sent as the count byte of a block read, which does not stop after that many bytes.
// - index nine is a read-only part identity byte.
// - the device answers address d2 for write and d3 for read.
// - block write is index, count X, then X data bytes, each acknowledged.
// - block read sends the count first, then data, until the host sends not-acknowledge.
module stir_test_id_regs
    import stir_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_b_i,
    input  wire logic  scl_i,
    input  wire logic  sda_i,
    output logic       sda_o,
    output logic       sda_oe_b_o,
    input  wire logic  test_sel_i,
    input  wire logic  test_out_sel_i,
    output logic [1:0] out_mode_o,
    output logic       test_active_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] pin_s;
    logic       scl_s;
    logic       sda_s;
    logic       tsel_s;
    logic       tout_s;

    assign pin_raw = {test_out_sel_i, test_sel_i, sda_i, scl_i};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        stir_sync u_sync (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .d_i     (pin_raw[g]),
            .q_o     (pin_s[g])
        );
    end

    assign scl_s  = pin_s[0];
    assign sda_s  = pin_s[1];
    assign tsel_s = pin_s[2];
    assign tout_s = pin_s[3];

    // ------------------------------------------------------------
    // bus edge and condition detection
    // ------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    wire  scl_rise = scl_s & ~scl_q;
    wire  scl_fall = ~scl_s & scl_q;
    wire  start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire  stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // ------------------------------------------------------------
    // registers and test mode state
    // ------------------------------------------------------------
    logic [7:0] test_ctrl_q;
    logic [7:0] read_len_q;
    logic       strap_done_q;
    logic       strap_q;
    logic       reg_test_q;
    logic [1:0] strap_wait_q;

    wire [7:0] maker_rev = {STIR_REV_CODE, STIR_MAKER_CODE};
    wire       test_type = test_ctrl_q[STIR_TEST_TYPE_POS];

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    stir_state_type state_q;
    logic [7:0]     shift_q;
    logic [2:0]     bit_q;
    logic [7:0]     idx_q;
    logic [7:0]     cnt_q;
    logic           rd_q;
    logic           drive_q;
    logic           bit_seen_q;

    wire       byte_done = scl_fall & bit_seen_q & (bit_q == 3'd0);
    wire [7:0] rx_byte   = shift_q;
    wire       addr_hit  = (rx_byte[7:1] == STIR_DEV_ADDR);
    wire       wr_hit    = rx_byte[0] == STIR_DIR_WRITE;

    logic [7:0] rd_data;
    always_comb begin
        case (idx_q)
            STIR_IDX_TEST_CTRL: rd_data = test_ctrl_q;
            STIR_IDX_MAKER_REV: rd_data = maker_rev;
            STIR_IDX_READ_LEN:  rd_data = read_len_q;
            STIR_IDX_PART_ID:   rd_data = STIR_PART_CODE;
            default:            rd_data = 8'h00;
        endcase
    end

    wire       do_write  = (state_q == STIR_ST_WDATA) & byte_done & (cnt_q != 8'h00);
    wire [7:0] wbyte     = shift_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q      <= STIR_ST_IDLE;
            shift_q      <= 8'h00;
            bit_q        <= 3'd7;
            idx_q        <= 8'h00;
            cnt_q        <= 8'h00;
            rd_q         <= 1'b0;
            drive_q      <= 1'b0;
            bit_seen_q   <= 1'b0;
        end else if (stop_c) begin
            state_q <= STIR_ST_IDLE;
            drive_q <= 1'b0;
        end else if (start_c) begin
            state_q    <= STIR_ST_ADDR;
            bit_q      <= 3'd7;
            drive_q    <= 1'b0;
            bit_seen_q <= 1'b0;
        end else begin
            // the fall that ends a start carries no bit and must not count
            if (scl_rise) begin
                bit_seen_q <= 1'b1;
            end else if (scl_fall) begin
                bit_seen_q <= 1'b0;
            end
            if (scl_rise && (state_q == STIR_ST_ADDR || state_q == STIR_ST_INDEX ||
                             state_q == STIR_ST_COUNT || state_q == STIR_ST_WDATA)) begin
                shift_q <= {shift_q[6:0], sda_s};
            end
            case (state_q)
                STIR_ST_ADDR, STIR_ST_INDEX, STIR_ST_COUNT, STIR_ST_WDATA: begin
                    if (scl_fall && bit_seen_q) begin
                        bit_q <= bit_q - 3'd1;
                    end
                    if (byte_done) begin
                        bit_q   <= 3'd7;
                        drive_q <= 1'b1;
                        case (state_q)
                            STIR_ST_ADDR: begin
                                if (addr_hit) begin
                                    state_q <= STIR_ST_ADDR_ACK;
                                    rd_q    <= ~wr_hit;
                                end else begin
                                    state_q <= STIR_ST_SKIP;
                                    drive_q <= 1'b0;
                                end
                            end
                            STIR_ST_INDEX: state_q <= STIR_ST_INDEX_ACK;
                            STIR_ST_COUNT: begin
                                state_q <= STIR_ST_COUNT_ACK;
                                cnt_q   <= shift_q;
                            end
                            default: begin
                                state_q <= STIR_ST_WDATA_ACK;
                                if (cnt_q != 8'h00) begin
                                    cnt_q <= cnt_q - 8'h01;
                                    idx_q <= idx_q + 8'h01;
                                end
                            end
                        endcase
                    end
                end
                STIR_ST_ADDR_ACK, STIR_ST_INDEX_ACK, STIR_ST_COUNT_ACK, STIR_ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        drive_q <= 1'b0;
                        case (state_q)
                            STIR_ST_ADDR_ACK: begin
                                state_q <= rd_q ? STIR_ST_RDATA : STIR_ST_INDEX;
                                drive_q <= rd_q;
                                shift_q <= read_len_q;
                            end
                            STIR_ST_INDEX_ACK: begin
                                idx_q   <= shift_q;
                                state_q <= STIR_ST_COUNT;
                            end
                            default: state_q <= STIR_ST_WDATA;
                        endcase
                    end
                end
                STIR_ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_q == 3'd0) begin
                            drive_q <= 1'b0;
                            bit_q   <= 3'd7;
                            state_q <= STIR_ST_RDATA_ACK;
                        end else begin
                            bit_q   <= bit_q - 3'd1;
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                STIR_ST_RDATA_ACK: begin
                    // host nack ends the read; data then idles until stop
                    if (scl_rise) begin
                        state_q <= sda_s ? STIR_ST_SKIP : STIR_ST_RDATA_ACK;
                    end
                    if (scl_fall) begin
                        state_q <= STIR_ST_RDATA;
                        drive_q <= 1'b1;
                        shift_q <= rd_data;
                        idx_q   <= idx_q + 8'h01;
                    end
                end
                STIR_ST_IDLE, STIR_ST_SKIP: drive_q <= 1'b0;
                default:                    state_q <= STIR_ST_IDLE;
            endcase
        end
    end

    // first data byte must be the addressed one, so fetch uses idx before increment
    wire rd_bit = shift_q[7];
    assign sda_o      = (state_q == STIR_ST_RDATA) ? rd_bit : 1'b0;
    assign sda_oe_b_o = ~drive_q;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    wire [7:0] widx   = idx_q;
    wire       wr_tc  = do_write & (widx == STIR_IDX_TEST_CTRL);
    wire       wr_len = do_write & (widx == STIR_IDX_READ_LEN);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            test_ctrl_q <= STIR_TEST_CTRL_RST;
            read_len_q  <= STIR_READ_LEN_RST;
        end else begin
            if (wr_tc) begin
                test_ctrl_q <= (wbyte & STIR_TEST_CTRL_WMSK) |
                               (STIR_TEST_CTRL_RST & ~STIR_TEST_CTRL_WMSK);
            end
            if (wr_len) begin
                read_len_q <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // test mode selection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_done_q <= 1'b0;
            strap_q      <= 1'b0;
            reg_test_q   <= 1'b0;
            strap_wait_q <= 2'b00;
        end else begin
            // wait until the synchroniser holds the pin rather than its reset value
            strap_wait_q <= {strap_wait_q[0], 1'b1};
            if (strap_wait_q[1] && !strap_done_q) begin
                strap_done_q <= 1'b1;
                strap_q      <= tsel_s;
            end
            // sticky: no write clears it, only power-up reset
            if (test_ctrl_q[STIR_TEST_ENTRY_POS] && strap_done_q && !strap_q) begin
                reg_test_q <= 1'b1;
            end
        end
    end

    stir_out_mode_type mode;
    always_comb begin
        if (strap_q) begin
            mode = (!tout_s && !test_type) ? STIR_OUT_HIZ : STIR_OUT_REFDIV;
        end else if (reg_test_q) begin
            mode = test_type ? STIR_OUT_REFDIV : STIR_OUT_HIZ;
        end else begin
            mode = STIR_OUT_NORMAL;
        end
    end

    assign out_mode_o    = mode;
    assign test_active_o = strap_q | reg_test_q;

endmodule : stir_test_id_regs

// ### verif/stir_test_id_regs_assertions.sv
`timescale 1ns/1ps

module stir_checker
    import stir_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       sda_o,
    input  wire logic       sda_oe_b_o,
    input  wire logic       test_sel_i,
    input  wire logic       test_out_sel_i,
    input  wire logic [1:0] out_mode_o,
    input  wire logic       test_active_o
);
    logic [3:0] cnt_q;
    logic       strap_q;
    // own copy of the strap, taken at the first edge after release
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q   <= 4'h0;
            strap_q <= 1'b0;
        end else begin
            if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h0) strap_q <= test_sel_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_normal_when_idle: assert property (!test_active_o |-> out_mode_o == STIR_OUT_NORMAL)
        else $error("outputs not normal outside test mode");
    chk_test_not_normal: assert property (test_active_o |-> out_mode_o != STIR_OUT_NORMAL)
        else $error("outputs normal in test mode");
    chk_test_sticky: assert property (test_active_o |=> test_active_o)
        else $error("test mode left without power cycle");
    chk_strap_enters: assert property (strap_q && cnt_q == 4'hc |-> test_active_o)
        else $error("strap did not enter test mode");
    chk_strap_refdiv: assert property ((strap_q && test_active_o && test_out_sel_i)[*4]
        |-> out_mode_o == STIR_OUT_REFDIV)
        else $error("strap mode with pin high not divided reference");
    // idle bus means no write can land, so only the pin could move the mode
    chk_reg_pin_ignored: assert property ((!strap_q && test_active_o && scl_i && sda_i)[*8]
        |-> $stable(out_mode_o))
        else $error("register test mode follows test output pin");
    chk_idle_no_entry: assert property ((!strap_q && cnt_q == 4'hf && scl_i && sda_i)[*8]
        |-> $stable(test_active_o))
        else $error("test mode changed without a register write");
    chk_sda_stable_high: assert property (scl_i[*2] |-> $stable(sda_oe_b_o))
        else $error("data enable moved while clock high");
endmodule : stir_checker

bind stir_test_id_regs stir_checker stir_checker_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
    .test_sel_i(test_sel_i), .test_out_sel_i(test_out_sel_i), .out_mode_o(out_mode_o),
    .test_active_o(test_active_o));

// ### verif/stir_host_model.sv
`timescale 1ns/1ps

module stir_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_drv_o
);
    logic [7:0] rbuf [0:4];
    initial begin
        scl_o     = 1'b1;
        sda_drv_o = 1'b1;
    end
    // half period of ten cycles, above the eight the device needs
    task automatic half(); repeat (10) @(posedge clk_i); #1; endtask : half
    task automatic clk_bit(input logic b, output logic s);
        sda_drv_o = b;
        half();
        scl_o = 1'b1;
        half();
        s = sda_i;
        scl_o = 1'b0;
    endtask : clk_bit
    task automatic start();
        sda_drv_o = 1'b1; half(); scl_o = 1'b1; half(); sda_drv_o = 1'b0; half(); scl_o = 1'b0;
    endtask : start
    task automatic stop();
        sda_drv_o = 1'b0; half(); scl_o = 1'b1; half(); sda_drv_o = 1'b1; half();
    endtask : stop
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : send
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(last, s);
    endtask : recv
    task automatic wr(input logic [7:0] a, input logic [7:0] idx, input logic [7:0] d,
                      output logic ok);
        logic k0, k1, k2, k3;
        start();
        send(a, k0);
        send(idx, k1);
        send(8'h01, k2);
        send(d, k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask : wr
    task automatic rd(input logic [7:0] idx, input int n);
        logic k;
        start();
        send(8'hd2, k);
        send(idx, k);
        start();
        send(8'hd3, k);
        for (int i = 0; i <= n; i++) recv(i == n, rbuf[i]);
        stop();
    endtask : rd
endmodule : stir_host_model

// ### verif/stir_test_id_regs_tb.sv
`timescale 1ns/1ps

module stir_test_id_regs_tb;
    import stir_pkg::*;
    logic       clk_i = 1'b0, rst_b_i = 1'b0, test_sel_i = 1'b0, test_out_sel_i = 1'b0, ok;
    logic [7:0] d, wa, tbl [0:3];
    wire        scl, sda_drv, sda_o, sda_oe_b_o, test_active_o;
    wire  [1:0] out_mode_o;
    wire        sda_w = sda_drv & (sda_oe_b_o | sda_o);
    int         miscompares = 0, tests_run = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    stir_test_id_regs stir_test_id_regs_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .test_sel_i(test_sel_i),
        .test_out_sel_i(test_out_sel_i), .out_mode_o(out_mode_o),
        .test_active_o(test_active_o));
    stir_host_model stir_host_model_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_drv_o(sda_drv));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [1:0] exp_mode(input logic act, strap, sel, typ);
        if (!act) return STIR_OUT_NORMAL;
        if (typ || (strap && sel)) return STIR_OUT_REFDIV;
        return STIR_OUT_HIZ;
    endfunction : exp_mode
    task automatic mode_chk(input logic act, strap, typ);
        repeat (4) @(posedge clk_i);
        #1;
        chk("test_active", {7'h0, act}, {7'h0, test_active_o});
        chk("out_mode", {6'h0, exp_mode(act, strap, test_out_sel_i, typ)}, {6'h0, out_mode_o});
    endtask : mode_chk
    task automatic do_reset(input logic s);
        rst_b_i <= 1'b0;
        test_sel_i <= s;
        repeat (10) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
    endtask : do_reset
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        d = 8'($urandom(90));
        wa = {STIR_DEV_ADDR, STIR_DIR_WRITE};
        tbl = '{8'h40, 8'h40, 8'hc0, 8'h00};
        do_reset(1'b0);
        stir_host_model_i.rd(STIR_IDX_TEST_CTRL, 4);
        chk("count", STIR_READ_LEN_RST, stir_host_model_i.rbuf[0]);
        chk("test_ctrl", STIR_TEST_CTRL_RST, stir_host_model_i.rbuf[1]);
        chk("identity", {STIR_REV_CODE, STIR_MAKER_CODE}, stir_host_model_i.rbuf[2]);
        chk("read_len", STIR_READ_LEN_RST, stir_host_model_i.rbuf[3]);
        chk("part", STIR_PART_CODE, stir_host_model_i.rbuf[4]);
        mode_chk(1'b0, 1'b0, 1'b0);
        $display("test reset_values done");
        test_sel_i = 1'b1;
        d = 8'($urandom);
        stir_host_model_i.wr(wa, STIR_IDX_MAKER_REV, ~d, ok);
        chk("ack", 8'h01, {7'h0, ok});
        stir_host_model_i.wr(wa, STIR_IDX_PART_ID, ~d, ok);
        stir_host_model_i.wr(wa, STIR_IDX_READ_LEN, d, ok);
        stir_host_model_i.wr(wa, STIR_IDX_TEST_CTRL, d & 8'h3f, ok);
        stir_host_model_i.wr({STIR_DEV_ADDR ^ 7'h01, STIR_DIR_WRITE}, STIR_IDX_READ_LEN, ~d, ok);
        chk("bad_addr_ack", 8'h00, {7'h0, ok});
        stir_host_model_i.rd(STIR_IDX_TEST_CTRL, 4);
        chk("count", d, stir_host_model_i.rbuf[0]);
        chk("test_ctrl", STIR_TEST_CTRL_RST, stir_host_model_i.rbuf[1]);
        chk("identity", {STIR_REV_CODE, STIR_MAKER_CODE}, stir_host_model_i.rbuf[2]);
        chk("read_len", d, stir_host_model_i.rbuf[3]);
        chk("part", STIR_PART_CODE, stir_host_model_i.rbuf[4]);
        mode_chk(1'b0, 1'b0, 1'b0);
        $display("test access_kinds done");
        for (int i = 0; i < 4; i++) begin
            test_out_sel_i = i[0];
            stir_host_model_i.wr(wa, STIR_IDX_TEST_CTRL, tbl[i], ok);
            mode_chk(1'b1, 1'b0, tbl[i][7]);
        end
        $display("test register_entry done");
        do_reset(1'b1);
        for (int i = 0; i < 4; i++) begin
            test_out_sel_i = i[0];
            stir_host_model_i.wr(wa, STIR_IDX_TEST_CTRL, {i[1], 7'h00}, ok);
            mode_chk(1'b1, 1'b1, i[1]);
        end
        $display("test strap_entry done");
        give_verdict();
    end
endmodule : stir_test_id_regs_tb
